// File: logic/psc_top.sv
`timescale 1ns/1ps
module psc_top
   import psc_pkg::*;
(
   // clock and reset
   input  wire logic                   clock_in,
   input  wire logic                   rst_b_in,
   input  wire logic                   soft_rst_in,
   // strap pins, shared with other functions
   input  wire logic [PSC_NPORT-1:0]   portx_powerdown_strap_in,
   input  wire logic [PSC_NPORT-1:0]   portx_high_amplitude_strap_in,
   input  wire logic                   spi_protocol_strap_low_in,
   input  wire logic                   spi_protocol_strap_high_in,
   // host register writes via the bridge, plus autoneg done and line receive inputs
   input  wire psc_pd_wr_t [PSC_NPORT-1:0] pd_wr_in,
   input  wire logic [PSC_NPORT-1:0]   hi_amp_req_in,
   input  wire logic [PSC_NPORT-1:0]   aneg_en_in,
   input  wire logic [PSC_NPORT-1:0]   aneg_done_in,
   input  wire logic [PSC_NPORT-1:0]   line_rx_in,
   // per-port outputs
   output psc_port_stat_t [PSC_NPORT-1:0] port_stat_out,
   output logic [PSC_NPORT-1:0]        phy_powerdown_control_reg_out,
   output logic [PSC_NPORT-1:0]        hi_amp_mode_out,
   output logic [PSC_NPORT-1:0]        line_rx_gated_out,
   output logic [PSC_NPORT-1:0]        phy_lowpower_out,
   // device-wide outputs
   output psc_spi_mode_t               spi_mode_out,
   output logic                        cut_through_out,
   output logic                        pll_run_out,
   output logic                        reg_access_ok_out,
   output logic                        straps_valid_out
);
   psc_state_t               state_r;
   logic                     capture;
   logic [PSC_NPORT-1:0]     amp_strap_q;
   logic                     spi_lo_q;
   logic                     spi_hi_q;
   logic [PSC_NPORT-1:0]     pd_bit;
   logic [PSC_NPORT-1:0]     start;
   logic [PSC_NPORT-1:0]     link_allow;
   logic [PSC_NPORT-1:0]     able;
   logic [PSC_NPORT-1:0]     hi_amp_r;
   psc_port_stat_t [PSC_NPORT-1:0] stat_r;
   logic [PSC_NPORT-1:0]     pdctl_r;
   logic [PSC_NPORT-1:0]     rxg_r;
   logic [PSC_NPORT-1:0]     lowp_r;
   psc_spi_mode_t            spi_mode_r;
   logic                     valid_r;

   // straps are taken in the first cycle after any reset
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r <= PSC_ST_SAMPLE;
      end else begin
         case (state_r)
            PSC_ST_SAMPLE: state_r <= PSC_ST_RUN;
            PSC_ST_RUN: begin
               if (soft_rst_in) begin
                  state_r <= PSC_ST_SAMPLE;
               end
            end
            default: state_r <= PSC_ST_SAMPLE;
         endcase
      end
   end

   assign capture = (state_r == PSC_ST_SAMPLE);

   // per-port straps and powerdown control
   genvar gi;
   generate
      for (gi = 0; gi < PSC_NPORT; gi++) begin : g_port
         psc_strap_latch #(
            .FLOAT_VAL (PSC_AMP_STRAP_FLOAT)
         ) u_amp_strap (
            .clock_in   (clock_in),
            .rst_b_in   (rst_b_in),
            .capture_in (capture),
            .pin_in     (portx_high_amplitude_strap_in[gi]),
            .value_out  (amp_strap_q[gi])
         );
         psc_port_ctrl u_ctrl (
            .clock_in      (clock_in),
            .rst_b_in      (rst_b_in),
            .load_in       (capture),
            .pd_strap_in   (portx_powerdown_strap_in[gi]),
            .pd_wr_in      (capture ? '0 : pd_wr_in[gi]),
            .aneg_en_in    (aneg_en_in[gi]),
            .link_allow_in (link_allow[gi]),
            .pd_bit_out    (pd_bit[gi]),
            .start_out     (start[gi])
         );
      end
   endgenerate

   // phy two links only once phy one is released
   always_comb begin
      link_allow[0] = 1'h1;
      link_allow[1] = !pd_bit[0];
   end

   // floating spi straps select alliance framing with protection
   psc_strap_latch #(.FLOAT_VAL(PSC_SPI_ALLIANCE_PROT[0])) u_spi_lo (
      .clock_in   (clock_in),
      .rst_b_in   (rst_b_in),
      .capture_in (capture),
      .pin_in     (spi_protocol_strap_low_in),
      .value_out  (spi_lo_q)
   );
   psc_strap_latch #(.FLOAT_VAL(PSC_SPI_ALLIANCE_PROT[1])) u_spi_hi (
      .clock_in   (clock_in),
      .rst_b_in   (rst_b_in),
      .capture_in (capture),
      .pin_in     (spi_protocol_strap_high_in),
      .value_out  (spi_hi_q)
   );

   // high amplitude ability from one strap level
   function automatic logic amp_able(input logic strap);
      return (strap == PSC_HIAMP_STRAP_ENABLE);
   endfunction

   // ability follows the latched strap, so later pin activity cannot move it
   always_comb begin
      for (int i = 0; i < PSC_NPORT; i++) begin
         able[i] = amp_able(amp_strap_q[i]);
      end
   end

   // amplitude mode from strap; host may only pick within ability
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hi_amp_r <= '0;
      end else if (capture) begin
         for (int i = 0; i < PSC_NPORT; i++) begin
            hi_amp_r[i] <= amp_able(portx_high_amplitude_strap_in[i]);
         end
      end else begin
         hi_amp_r <= hi_amp_req_in & able;
      end
   end

   // per-port status and gating
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stat_r  <= '0;
         pdctl_r <= '1;
         rxg_r   <= '0;
         lowp_r  <= '1;
      end else begin
         for (int i = 0; i < PSC_NPORT; i++) begin
            stat_r[i].pd_reached  <= pd_bit[i];
            stat_r[i].link_enable <= !pd_bit[i] && link_allow[i] && aneg_done_in[i];
            stat_r[i].aneg_start  <= start[i];
            stat_r[i].hi_amp_able <= able[i];
            pdctl_r[i]            <= pd_bit[i];
            rxg_r[i]              <= line_rx_in[i] && !pd_bit[i];
            lowp_r[i]             <= pd_bit[i];
         end
      end
   end

   // spi protocol decode
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         spi_mode_r <= PSC_SPI_MODE_ALLIANCE_PROT;
         valid_r    <= 1'h0;
      end else begin
         case ({spi_hi_q, spi_lo_q})
            PSC_SPI_ALLIANCE_PROT: spi_mode_r <= PSC_SPI_MODE_ALLIANCE_PROT;
            PSC_SPI_ALLIANCE_RAW:  spi_mode_r <= PSC_SPI_MODE_ALLIANCE_RAW;
            PSC_SPI_GENERIC_CRC:   spi_mode_r <= PSC_SPI_MODE_GENERIC_CRC;
            PSC_SPI_GENERIC_RAW:   spi_mode_r <= PSC_SPI_MODE_GENERIC_RAW;
            default:               spi_mode_r <= PSC_SPI_MODE_ALLIANCE_PROT;
         endcase
         valid_r <= !capture;
      end
   end

   // cut-through and pll outputs held at one in flops; access flag low only in reset
   logic ct_r;
   logic pll_r;
   logic acc_r;
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ct_r  <= 1'h1;
         pll_r <= 1'h1;
         acc_r <= 1'h0;
      end else begin
         ct_r  <= 1'h1;
         pll_r <= 1'h1;
         acc_r <= 1'h1;
      end
   end

   assign port_stat_out                 = stat_r;
   assign phy_powerdown_control_reg_out = pdctl_r;
   assign hi_amp_mode_out               = hi_amp_r;
   assign line_rx_gated_out             = rxg_r;
   assign phy_lowpower_out              = lowp_r;
   assign spi_mode_out                  = spi_mode_r;
   assign cut_through_out               = ct_r;
   assign pll_run_out                   = pll_r;
   assign reg_access_ok_out             = acc_r;
   assign straps_valid_out              = valid_r;
endmodule

// File: logic/psc_pkg.sv
package psc_pkg;
   // number of phy ports
   localparam int unsigned PSC_NPORT = 2;
   // strap decode for powerdown: a low strap means powered down after reset
   localparam logic PSC_SWPD_STRAP_ACTIVE = 1'h1;
   // amplitude strap: a low strap enables the high level
   localparam logic PSC_HIAMP_STRAP_ENABLE = 1'h0;
   // floating-pin defaults, set by the internal pulls
   localparam logic PSC_P1_PD_STRAP_FLOAT = 1'h0;
   localparam logic PSC_P2_PD_STRAP_FLOAT = 1'h1;
   localparam logic PSC_AMP_STRAP_FLOAT   = 1'h0;
   // spi protocol straps {high, low}
   localparam logic [1:0] PSC_SPI_ALLIANCE_PROT = 2'h0;
   localparam logic [1:0] PSC_SPI_ALLIANCE_RAW  = 2'h1;
   localparam logic [1:0] PSC_SPI_GENERIC_CRC   = 2'h2;
   localparam logic [1:0] PSC_SPI_GENERIC_RAW   = 2'h3;

   typedef enum logic [1:0] {
      PSC_SPI_MODE_ALLIANCE_PROT = 2'b00,
      PSC_SPI_MODE_ALLIANCE_RAW  = 2'b01,
      PSC_SPI_MODE_GENERIC_CRC   = 2'b10,
      PSC_SPI_MODE_GENERIC_RAW   = 2'b11
   } psc_spi_mode_t;

   // sequencer states
   typedef enum logic [1:0] {
      PSC_ST_SAMPLE = 2'b00,
      PSC_ST_RUN    = 2'b01
   } psc_state_t;

   // per-port link status bundle
   typedef struct packed {
      logic pd_reached;   // status flag
      logic link_enable;  // link may come up
      logic aneg_start;   // one-cycle start pulse
      logic hi_amp_able;  // high amplitude ability
   } psc_port_stat_t;

   // host write to a port's powerdown bit
   typedef struct packed {
      logic wr;
      logic val;
   } psc_pd_wr_t;
endpackage

// File: logic/psc_strap_latch.sv
`timescale 1ns/1ps
// captures one strap level once per reset event
module psc_strap_latch
   import psc_pkg::*;
#(
   parameter logic FLOAT_VAL = 1'h0
) (
   // clock and reset
   input  wire logic clock_in,
   input  wire logic rst_b_in,
   // sampling
   input  wire logic capture_in,
   input  wire logic pin_in,
   // latched value
   output logic      value_out
);
   logic value_r;

   // load on the capture cycle only, hold otherwise
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         value_r <= FLOAT_VAL;
      end else if (capture_in) begin
         value_r <= pin_in;
      end
   end

   assign value_out = value_r;
endmodule

// File: logic/psc_port_ctrl.sv
`timescale 1ns/1ps
// one phy's software powerdown control bit and status
module psc_port_ctrl
   import psc_pkg::*;
(
   // clock and reset
   input  wire logic           clock_in,
   input  wire logic           rst_b_in,
   // strap load
   input  wire logic           load_in,
   input  wire logic           pd_strap_in,
   // host write and link gating
   input  wire psc_pd_wr_t     pd_wr_in,
   input  wire logic           aneg_en_in,
   input  wire logic           link_allow_in,
   // state
   output logic                pd_bit_out,
   output logic                start_out
);
   logic pd_bit_r;
   logic pd_bit_nxt;
   logic start_r;

   // powerdown bit: strap load first, then host writes
   always_comb begin
      pd_bit_nxt = pd_bit_r;
      if (load_in) begin
         pd_bit_nxt = (pd_strap_in != PSC_SWPD_STRAP_ACTIVE);
      end else if (pd_wr_in.wr) begin
         pd_bit_nxt = pd_wr_in.val;
      end
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pd_bit_r <= 1'h1;
      end else begin
         pd_bit_r <= pd_bit_nxt;
      end
   end

   // start pulse when the phy becomes active with autoneg on and its link allowed
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         start_r <= 1'h0;
      end else begin
         start_r <= pd_bit_r && !pd_bit_nxt && aneg_en_in && link_allow_in;
      end
   end

   assign pd_bit_out = pd_bit_r;
   assign start_out  = start_r;
endmodule

// File: verification/psc_top_sva.sv
`timescale 1ns/1ps
// powerdown, strap and link checks at the top ports
module psc_top_sva
   import psc_pkg::*;
(
   // clock and reset
   input wire logic                           clock_in,
   input wire logic                           rst_b_in,
   input wire logic                           soft_rst_in,
   // host writes
   input wire psc_pd_wr_t [PSC_NPORT-1:0]     pd_wr_in,
   // watched outputs
   input wire psc_port_stat_t [PSC_NPORT-1:0] port_stat_out,
   input wire logic [PSC_NPORT-1:0]           phy_powerdown_control_reg_out,
   input wire logic [PSC_NPORT-1:0]           hi_amp_mode_out,
   input wire logic [PSC_NPORT-1:0]           line_rx_gated_out,
   input wire logic [PSC_NPORT-1:0]           phy_lowpower_out,
   input wire psc_spi_mode_t                  spi_mode_out,
   input wire logic                           cut_through_out,
   input wire logic                           pll_run_out,
   input wire logic                           straps_valid_out
);
   logic [2:0] quiet_r;
   logic [1:0] pd;
   logic [1:0] lp;
   logic [1:0] able;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   // short aliases
   assign pd = phy_powerdown_control_reg_out;
   assign lp = phy_lowpower_out;
   assign able = {port_stat_out[1].hi_amp_able, port_stat_out[0].hi_amp_able};
   // cycles since the last port 1 write or soft reset
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) quiet_r <= 3'h0;
      else if (pd_wr_in[0].wr || soft_rst_in) quiet_r <= 3'h0;
      else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
   end
   a_pll_running: assert property (pll_run_out)
      else $error("pll stopped");
   a_cut_through: assert property (cut_through_out)
      else $error("forwarding not cut-through");
   a_rx_ignored: assert property (lp[0] && $past(lp[0]) |-> !line_rx_gated_out[0])
      else $error("line input passed while powered down");
   a_link_dropped: assert property ((pd[0] && $stable(pd[0]))[*3] |-> !port_stat_out[0].link_enable && !port_stat_out[1].link_enable)
      else $error("link enabled while port 1 powered down");
   a_status_tracks: assert property ($stable(pd)[*6] |-> lp == pd && {port_stat_out[1].pd_reached, port_stat_out[0].pd_reached} == pd)
      else $error("powerdown flag differs from control bit");
   a_write_sets: assert property (pd_wr_in[0].wr && pd_wr_in[0].val && straps_valid_out |-> ##[1:3] pd[0])
      else $error("write of one did not power down");
   a_write_clears: assert property (pd_wr_in[0].wr && !pd_wr_in[0].val && straps_valid_out |-> ##[1:3] !pd[0])
      else $error("write of zero did not release");
   a_pd_held: assert property (quiet_r >= 3'h4 |-> !$fell(pd[0]))
      else $error("powerdown left without a write");
   a_straps_held: assert property (quiet_r >= 3'h4 |-> $stable({spi_mode_out, able}))
      else $error("strapped setting changed");
   a_amp_masked: assert property (quiet_r >= 3'h4 |-> (hi_amp_mode_out & ~able) == 2'h0)
      else $error("high amplitude without ability");
   c_release: cover property ($fell(pd[0]));
   c_start: cover property (port_stat_out[0].aneg_start);
   c_port2_link: cover property (port_stat_out[1].link_enable);
endmodule
bind psc_top psc_top_sva u_sva (
   .clock_in, .rst_b_in, .soft_rst_in, .pd_wr_in, .port_stat_out,
   .phy_powerdown_control_reg_out, .hi_amp_mode_out, .line_rx_gated_out,
   .phy_lowpower_out, .spi_mode_out, .cut_through_out, .pll_run_out, .straps_valid_out
);

// File: verification/psc_host_model.sv
`timescale 1ns/1ps
// host behind the bridge: turns requests into one-cycle bit writes
module psc_host_model
   import psc_pkg::*;
(
   // clock and reset
   input  wire logic                  clock_in,
   input  wire logic                  rst_b_in,
   // request from the bench
   input  wire logic                  go_in,
   input  wire logic                  port_in,
   input  wire logic                  val_in,
   // bridge writes
   output psc_pd_wr_t [PSC_NPORT-1:0] pd_wr_out
);
   // write pulse; idle data shows the inverse of its last value
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pd_wr_out <= '0;
      end else begin
         for (int i = 0; i < PSC_NPORT; i++) begin
            pd_wr_out[i].wr <= go_in && (port_in == i[0]);
            pd_wr_out[i].val <= (go_in && port_in == i[0]) ? val_in : ~pd_wr_out[i].val;
         end
      end
   end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
// strap sampling, powerdown control and link gating
module testbench
   import psc_pkg::*;
();
   typedef struct packed {
      logic [1:0] pd, amp, spi, ctl, able, mode;
   } psc_tb_row_t;
   localparam psc_tb_row_t ROWS [4] = '{12'h03c, 12'h569, 12'ha96, 12'hfc3};
   logic                           clock_in, rst_b_in, soft_rst_in, go, port, val;
   logic                           spi_protocol_strap_low_in, spi_protocol_strap_high_in;
   logic [1:0]                     portx_powerdown_strap_in, portx_high_amplitude_strap_in;
   logic [1:0]                     hi_amp_req_in, aneg_en_in, aneg_done_in, line_rx_in;
   logic [1:0]                     phy_powerdown_control_reg_out, hi_amp_mode_out;
   logic [1:0]                     line_rx_gated_out, phy_lowpower_out;
   logic                           cut_through_out, pll_run_out;
   logic                           reg_access_ok_out, straps_valid_out;
   psc_spi_mode_t                  spi_mode_out;
   psc_port_stat_t [PSC_NPORT-1:0] port_stat_out;
   psc_pd_wr_t [PSC_NPORT-1:0]     pd_wr_in;
   int                             n_fail, n_tests, cyc;
   logic [7:0]                     n_start, s0;
   wire [1:0]                      ctrl = phy_powerdown_control_reg_out;
   wire [1:0]                      flags = {port_stat_out[1].pd_reached,
                                            port_stat_out[0].pd_reached};

   psc_top DUT (.*);
   psc_host_model host (.clock_in, .rst_b_in, .go_in(go), .port_in(port), .val_in(val),
                        .pd_wr_out(pd_wr_in));

   // clock
   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   // cycle ceiling and start pulse count
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      n_start <= n_start + 8'(port_stat_out[0].aneg_start);
      if (cyc == 3000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic tick(int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic host_write(logic p, logic v);
      go <= 1'b1;
      port <= p;
      val <= v;
      tick(1);
      go <= 1'b0;
      tick(6);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      {rst_b_in, soft_rst_in, go, port, val} = '0;
      {spi_protocol_strap_high_in, spi_protocol_strap_low_in} = 2'h0;
      {n_fail, n_tests, cyc, n_start} = '0;
      portx_powerdown_strap_in = {PSC_P2_PD_STRAP_FLOAT, PSC_P1_PD_STRAP_FLOAT}; // floating levels
      portx_high_amplitude_strap_in = {2{PSC_AMP_STRAP_FLOAT}};
      {hi_amp_req_in, aneg_en_in, aneg_done_in, line_rx_in} = 8'hff;
      tick(3);
      check("control in reset", 8'h03, ctrl);
      check("valid in reset", 8'h00, straps_valid_out);
      tick(1);
      rst_b_in <= 1'b1;
      tick(6);
      $display("test reset done");
      check("floating pd", 8'h01, ctrl);
      check("pd flags", 8'h01, flags);
      check("port 2 link", 8'h00, port_stat_out[1].link_enable);
      check("rx gating", 8'h02, line_rx_gated_out);
      check("pll fwd", 8'h03, {pll_run_out, cut_through_out});
      check("access", 8'h01, reg_access_ok_out);
      check("spi default", 8'h00, spi_mode_out);
      $display("test floating straps done");
      s0 = n_start;
      host_write(1'b0, 1'b0);
      check("released", 8'h00, ctrl);
      check("start pulse", 8'h01, n_start - s0);
      check("port 2 link", 8'h01, port_stat_out[1].link_enable);
      check("rx passes", 8'h03, line_rx_gated_out);
      host_write(1'b1, 1'b1);
      check("port 2 pd", 8'h02, ctrl);
      check("pd flags", 8'h02, flags);
      check("low power", 8'h02, phy_lowpower_out);
      check("rx gating", 8'h01, line_rx_gated_out);
      check("port 2 link", 8'h00, port_stat_out[1].link_enable);
      host_write(1'b1, 1'b0);
      host_write(1'b0, 1'b1);
      check("port 1 pd", 8'h01, ctrl);
      check("port 2 link", 8'h00, port_stat_out[1].link_enable);
      $display("test host writes done");
      foreach (ROWS[i]) begin
         portx_powerdown_strap_in <= ROWS[i].pd;
         portx_high_amplitude_strap_in <= ROWS[i].amp;
         {spi_protocol_strap_high_in, spi_protocol_strap_low_in} <= ROWS[i].spi;
         soft_rst_in <= 1'b1;
         tick(1);
         soft_rst_in <= 1'b0;
         tick(6);
         // pins return to their other use
         portx_powerdown_strap_in <= ~ROWS[i].pd;
         portx_high_amplitude_strap_in <= ~ROWS[i].amp;
         {spi_protocol_strap_high_in, spi_protocol_strap_low_in} <= ~ROWS[i].spi;
         tick(4);
         check("strap pd", ROWS[i].ctl, ctrl);
         check("ability", ROWS[i].able, {port_stat_out[1].hi_amp_able,
                                         port_stat_out[0].hi_amp_able});
         check("spi mode", ROWS[i].mode, spi_mode_out);
      end
      $display("test strap table done");
      portx_powerdown_strap_in <= 2'h3;
      portx_high_amplitude_strap_in <= 2'h1;
      s0 = n_start;
      rst_b_in <= 1'b0;
      tick(4);
      rst_b_in <= 1'b1;
      tick(6);
      check("autoneg after reset", 8'h01, n_start - s0);
      check("amp mode", 8'h02, hi_amp_mode_out);
      $display("test autoneg and amplitude done");
      // autoneg off and port 2 not yet negotiated
      aneg_done_in <= 2'h1;
      aneg_en_in <= 2'h0;
      s0 = n_start;
      host_write(1'b0, 1'b1);
      host_write(1'b0, 1'b0);
      check("no autoneg", 8'h00, n_start - s0);
      check("port 1 link", 8'h01, port_stat_out[0].link_enable);
      check("port 2 link", 8'h00, port_stat_out[1].link_enable);
      $display("test autoneg gating done");
      complete_run();
   end
endmodule
